// >>> adc_gpio_config_frames.sv
// serial frame receiver, pin configuration register and pin muxing
`timescale 1ns/1ps
`include "adc_gpio_cfg.svh"
module adc_gpio_config_frames (
    // system
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // serial link
    input wire logic sclk,
    input wire logic csB,
    input wire logic sdi,
    output logic sdo,
    // pins
    input wire adc_gpio_pkg::pins_t pinIn,
    output adc_gpio_pkg::pins_t pinOut,
    output adc_gpio_pkg::pins_t pinOe,
    // converter side
    input wire adc_gpio_pkg::conv_t convData,
    input wire logic [3:0] chanAddr,
    input wire logic highAlarm,
    input wire logic lowAlarm,
    output logic powerDown,
    output logic rangeHigh
);
    import adc_gpio_pkg::*;

    // ---------------- link domain ----------------
    // chip-select high holds the bit counter and sdo at zero; sclk may stop
    logic frameRst_b;
    logic [4:0] bitCnt_q, bitCnt_d;
    frame_t shift_q, shift_d, word_q, word_d;
    logic doneTog_q, doneTog_d, sdo_q, sdo_d;
    frame_t txWord_q, txWord_d;

    assign frameRst_b = rst_b & ~csB;

    always_comb begin
        bitCnt_d = bitCnt_q;
        shift_d = {shift_q[`FRAME_BITS-2:0], sdi};
        sdo_d = 1'b0;
        if (bitCnt_q < 5'(`FRAME_BITS)) begin
            bitCnt_d = bitCnt_q + 5'h01;
            sdo_d = txWord_q[4'(`FRAME_BITS - 1) - bitCnt_q[3:0]];
        end
    end

    always_ff @(posedge sclk or negedge frameRst_b) begin
        if (!frameRst_b) begin
            bitCnt_q <= 5'h00;
            shift_q <= 16'h0000;
            sdo_q <= 1'b0;
        end else begin
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            sdo_q <= sdo_d;
        end
    end

    // the finished word is held across frame end; the toggle tells clk domain
    always_comb begin
        word_d = word_q;
        doneTog_d = doneTog_q;
        if (bitCnt_q == 5'(`FRAME_BITS - 1)) begin
            word_d = {shift_q[`FRAME_BITS-2:0], sdi};
            doneTog_d = ~doneTog_q;
        end
    end

    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            word_q <= 16'h0000;
            doneTog_q <= 1'b0;
        end else begin
            word_q <= word_d;
            doneTog_q <= doneTog_d;
        end
    end

    assign sdo = sdo_q;

    // ---------------- system domain ----------------
    pins_t pinS1_q, pinS2_q;
    logic csS1_q, csS2_q, csS3_q, dnS1_q, dnS2_q, dnS3_q;
    logic csFall, doneEvt;
    cmd_t rxCmd;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pinS1_q <= 4'h0;
            pinS2_q <= 4'h0;
            csS1_q <= 1'b1;
            csS2_q <= 1'b1;
            csS3_q <= 1'b1;
            dnS1_q <= 1'b0;
            dnS2_q <= 1'b0;
            dnS3_q <= 1'b0;
        end else if (ce) begin
            pinS1_q <= pinIn;
            pinS2_q <= pinS1_q;
            csS1_q <= csB;
            csS2_q <= csS1_q;
            csS3_q <= csS2_q;
            dnS1_q <= doneTog_q;
            dnS2_q <= dnS1_q;
            dnS3_q <= dnS2_q;
        end
    end

    assign csFall = csS3_q & ~csS2_q;
    assign doneEvt = dnS2_q ^ dnS3_q;
    assign rxCmd = cmd_t'(word_q[15:12]);

    // register state
    logic [`CFG_WIDTH-1:0] cfg_q, cfg_d;
    pins_t gpoPend_q, gpoPend_d, gpo_q, gpo_d, gpi_q, gpi_d;
    logic readEnPend_q, readEnPend_d, modePd_q, modePd_d;
    logic rangePend_q, rangePend_d, rangeBit_q, rangeBit_d;
    logic softRstPend_q, softRstPend_d, powerDown_q, powerDown_d;
    logic pdFunc, rangeFunc, modeFrame;
    logic [2:0] alarmSel;

    assign pdFunc = cfg_q[`PD_FUNC_BIT];
    assign rangeFunc = cfg_q[`RANGE_FUNC_BIT];
    assign alarmSel = cfg_q[6:4];
    assign modeFrame = (rxCmd != CMD_KEEP) && (rxCmd != CMD_CONFIG)
        && (word_q[15:14] != `CMD_ALARM_PREFIX);

    always_comb begin
        cfg_d = cfg_q;
        gpoPend_d = gpoPend_q;
        gpo_d = gpo_q;
        gpi_d = gpi_q;
        readEnPend_d = readEnPend_q;
        modePd_d = modePd_q;
        rangePend_d = rangePend_q;
        rangeBit_d = rangeBit_q;
        softRstPend_d = softRstPend_q;
        txWord_d = txWord_q;
        powerDown_d = powerDown_q;
        if (doneEvt) begin
            if (rxCmd == CMD_CONFIG) begin
                // output data and range stay untouched in this frame
                cfg_d = word_q[`CFG_WIDTH-1:0];
                softRstPend_d = word_q[`SOFT_RST_BIT];
            end else if (modeFrame) begin
                gpoPend_d = word_q[3:0];
                readEnPend_d = word_q[`READ_EN_BIT];
                modePd_d = word_q[`MODE_PD_BIT];
                rangePend_d = word_q[`RANGE_SEL_BIT];
            end
        end
        if (csFall) begin
            gpo_d = gpoPend_q;
            gpi_d = pinS2_q;
            rangeBit_d = rangePend_q;
            if (readEnPend_q) begin
                txWord_d = {chanAddr, convData[11:4], pinS2_q};
            end else begin
                txWord_d = {chanAddr, convData};
            end
            if (!modePd_q && !(pdFunc && !pinS2_q[3])) begin
                powerDown_d = 1'b0;
            end
            if (softRstPend_q) begin
                cfg_d = `CFG_RESET;
                gpoPend_d = 4'h0;
                gpo_d = 4'h0;
                readEnPend_d = 1'b0;
                modePd_d = 1'b0;
                rangePend_d = 1'b0;
                rangeBit_d = 1'b0;
                softRstPend_d = 1'b0;
            end
        end
        // the pin acts without waiting for a frame
        if ((pdFunc && !pinS2_q[3]) || modePd_q) begin
            powerDown_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= `CFG_RESET;
            gpoPend_q <= 4'h0;
            gpo_q <= 4'h0;
            gpi_q <= 4'h0;
            readEnPend_q <= 1'b0;
            modePd_q <= 1'b0;
            rangePend_q <= 1'b0;
            rangeBit_q <= 1'b0;
            softRstPend_q <= 1'b0;
            txWord_q <= 16'h0000;
            powerDown_q <= 1'b0;
        end else if (ce) begin
            cfg_q <= cfg_d;
            gpoPend_q <= gpoPend_d;
            gpo_q <= gpo_d;
            gpi_q <= gpi_d;
            readEnPend_q <= readEnPend_d;
            modePd_q <= modePd_d;
            rangePend_q <= rangePend_d;
            rangeBit_q <= rangeBit_d;
            softRstPend_q <= softRstPend_d;
            txWord_q <= txWord_d;
            powerDown_q <= powerDown_d;
        end
    end

    // ---------------- pin muxing ----------------
    pins_t isAlarm, alarmVal, special, pinOut_d, pinOe_d, pinOut_q, pinOe_q;
    logic rangeHigh_q, rangeHigh_d;

    always_comb begin
        isAlarm = 4'h0;
        alarmVal = 4'h0;
        special = {pdFunc, rangeFunc, 2'b00};
        if (alarmSel[0]) begin
            isAlarm[0] = 1'b1;
            alarmVal[0] = highAlarm | lowAlarm;
        end else if (alarmSel == `ALARM_HIGH) begin
            isAlarm[0] = 1'b1;
            alarmVal[0] = highAlarm;
        end else if (alarmSel == `ALARM_LOW) begin
            isAlarm[1] = 1'b1;
            alarmVal[1] = lowAlarm;
        end else if (alarmSel == `ALARM_BOTH) begin
            isAlarm[1:0] = 2'b11;
            alarmVal[1:0] = {lowAlarm, highAlarm};
        end
        rangeHigh_d = rangeFunc ? pinS2_q[2] : rangeBit_q;
    end

    for (genvar i = 0; i < 4; i++) begin : g_pin
        // direction only applies to pins left without a role
        assign pinOe_d[i] = isAlarm[i] | (~special[i] & cfg_q[i]);
        assign pinOut_d[i] = isAlarm[i] ? alarmVal[i] : (pinOe_d[i] & gpo_q[i]);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pinOut_q <= 4'h0;
            pinOe_q <= 4'h0;
            rangeHigh_q <= 1'b0;
        end else if (ce) begin
            pinOut_q <= pinOut_d;
            pinOe_q <= pinOe_d;
            rangeHigh_q <= rangeHigh_d;
        end
    end

    assign pinOut = pinOut_q;
    assign pinOe = pinOe_q;
    assign powerDown = powerDown_q;
    assign rangeHigh = rangeHigh_q;

    // ---------------- checks ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_gpo_update;
        csFall && ce && !softRstPend_q |=> gpo_q == $past(gpoPend_q);
    endproperty
    a_gpo_update: assert property (p_gpo_update) else $error("output data not refreshed");

    property p_gpi_send;
        csFall && ce && readEnPend_q && !softRstPend_q
            |=> gpi_q == $past(pinS2_q) && txWord_q[3:0] == $past(pinS2_q);
    endproperty
    a_gpi_send: assert property (p_gpi_send) else $error("input pins not sent");

    property p_cfg_hold_data;
        doneEvt && ce && rxCmd == CMD_CONFIG && !csFall
            |=> gpoPend_q == $past(gpoPend_q) && cfg_q == $past(word_q[11:0]);
    endproperty
    a_cfg_hold_data: assert property (p_cfg_hold_data) else $error("config frame wrong");

    property p_soft_reset;
        csFall && ce && softRstPend_q |=> cfg_q == `CFG_RESET && gpo_q == 4'h0
            && !softRstPend_q ##1 ce [*2] ##0 pinOe_q == 4'h0;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

    property p_pd_pin;
        ce && pdFunc && !pinS2_q[3] |=> powerDown_q && pinOe_q[3] == 1'b0;
    endproperty
    a_pd_pin: assert property (p_pd_pin) else $error("power-down pin ignored");

    property p_power_up;
        powerDown_q && csFall && ce && !modePd_q && pinS2_q[3] |=> !powerDown_q;
    endproperty
    a_power_up: assert property (p_power_up) else $error("no power up");

    property p_range_pin;
        ce && rangeFunc |=> rangeHigh_q == $past(pinS2_q[2]) && !pinOe_q[2];
    endproperty
    a_range_pin: assert property (p_range_pin) else $error("range pin ignored");

    property p_alarm_any;
        ce && alarmSel[0] |=> pinOe_q[0] && pinOut_q[0] == $past(highAlarm | lowAlarm);
    endproperty
    a_alarm_any: assert property (p_alarm_any) else $error("pin_zero alarm wrong");

    property p_alarm_both;
        ce && alarmSel == `ALARM_BOTH
            |=> pinOe_q[1:0] == 2'b11 && pinOut_q[1:0] == $past({lowAlarm, highAlarm});
    endproperty
    a_alarm_both: assert property (p_alarm_both) else $error("dual alarm wrong");

    property p_direction;
        ce && alarmSel == `ALARM_NONE && !pdFunc && !rangeFunc
            |=> pinOe_q == $past(cfg_q[3:0]);
    endproperty
    a_direction: assert property (p_direction) else $error("direction wrong");

    // checked on the falling edge: csB may rise right after the 16th rising edge
    property p_frame_len;
        @(negedge sclk) disable iff (!frameRst_b)
        bitCnt_q == 5'h10 && $past(bitCnt_q) == 5'h0F |-> doneTog_q != $past(doneTog_q);
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

    c_config: cover property (doneEvt && ce && rxCmd == CMD_CONFIG);
    c_soft_reset: cover property (csFall && ce && softRstPend_q);
    c_pd: cover property (ce && pdFunc && !pinS2_q[3] ##1 powerDown_q);
    c_read: cover property (csFall && ce && readEnPend_q);
endmodule

// >>> adc_gpio_cfg.svh
// constants for the serial pin configuration block
`ifndef ADC_GPIO_CFG_SVH
`define ADC_GPIO_CFG_SVH
`define FRAME_BITS 16
`define CMD_CONFIG 4'h4
`define CMD_KEEP 4'h0
`define CMD_ALARM_PREFIX 2'h3
`define CFG_WIDTH 12
`define CFG_RESET 12'h000
`define SOFT_RST_BIT 9
`define PD_FUNC_BIT 8
`define RANGE_FUNC_BIT 7
`define RANGE_SEL_BIT 6
`define MODE_PD_BIT 5
`define READ_EN_BIT 4
`define ALARM_ANY 3'h1
`define ALARM_HIGH 3'h2
`define ALARM_LOW 3'h4
`define ALARM_BOTH 3'h6
`define ALARM_NONE 3'h0
`endif

// >>> adc_gpio_pkg.sv
// types shared by the pin configuration block
`include "adc_gpio_cfg.svh"
package adc_gpio_pkg;
    typedef logic [`FRAME_BITS-1:0] frame_t;
    typedef logic [11:0] conv_t;
    typedef logic [3:0] pins_t;
    typedef enum logic [3:0] {
        CMD_KEEP = `CMD_KEEP,
        CMD_CONFIG = `CMD_CONFIG
    } cmd_t;
endpackage

// >>> host_link.sv
// host side model: sends 16-bit chip-select framed words and captures the reply
`timescale 1ns/1ps
module host_link (
    // serial link
    output logic sclk,
    output logic csB,
    output logic sdi,
    input wire logic sdo
);
    import adc_gpio_pkg::*;
    localparam time HALF = 32ns;
    initial begin
        sclk = 1'b0;
        csB = 1'b1;
        sdi = 1'b0;
    end
    // serial clock stands still low between frames
    task automatic send(input frame_t word, output frame_t reply);
        csB = 1'b0;
        sdi = word[15];
        // long setup: the reply word must cross into the link domain first
        #64ns;
        for (int i = 15; i >= 0; i--) begin
            sdi = word[i];
            #HALF sclk = 1'b1;
            #HALF sclk = 1'b0;
            reply[i] = sdo;
        end
        // released line shows the inverse so a stale level is never trusted
        sdi = ~sdi;
        #HALF csB = 1'b1;
        #100ns;
    endtask
endmodule

// >>> tb.sv
// self-checking bench for the serial pin configuration block
`timescale 1ns/1ps
module tb;
    import adc_gpio_pkg::*;
    logic clk, rst_b, sclk, csB, sdi, sdo, highAlarm, lowAlarm, powerDown, rangeHigh;
    logic ce;
    pins_t pinIn, pinOut, pinOe;
    conv_t convData;
    logic [3:0] chanAddr;
    frame_t rx;
    int failCount = 0;
    int samplesChecked = 0;

    adc_gpio_config_frames u_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .sclk(sclk),
        .csB(csB), .sdi(sdi), .sdo(sdo), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .convData(convData), .chanAddr(chanAddr), .highAlarm(highAlarm),
        .lowAlarm(lowAlarm), .powerDown(powerDown), .rangeHigh(rangeHigh));
    host_link u_host (.sclk(sclk), .csB(csB), .sdi(sdi), .sdo(sdo));

    always #5ns clk = ~clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] expd);
        samplesChecked++;
        if (seen !== expd) begin
            failCount++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, expd);
        end
    endtask

    task automatic closeOut();
        $display("comparisons %0d mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic frame(input frame_t w);
        @(negedge clk);
        u_host.send(w, rx);
        @(negedge clk);
    endtask

    // {oe1, oe0, out1, out0} for an alarm selection
    function automatic logic [3:0] alarm_exp(input logic [2:0] code, input logic h,
                                             input logic l);
        case (code)
            3'h1, 3'h3, 3'h5, 3'h7: return {2'h1, 1'b0, h | l};
            3'h2: return {2'h1, 1'b0, h};
            3'h4: return {2'h2, l, 1'b0};
            3'h6: return {2'h3, l, h};
            default: return 4'h0;
        endcase
    endfunction

    task automatic t_output();
        frame(16'h400F);
        frame(16'h100A);
        check(16'(pinOut), 16'h0000);
        check(16'(pinOe), 16'h000F);
        frame(16'h0000);
        check(16'(pinOut), 16'h000A);
        frame(16'h400F);
        frame(16'h0000);
        check(16'(pinOut), 16'h000A);
    endtask

    task automatic t_read();
        frame(16'h4000);
        check(16'(pinOe), 16'h0000);
        @(negedge clk) pinIn = 4'h9;
        frame(16'h1010);
        frame(16'h0000);
        check(rx, 16'h65C9);
        frame(16'h1000);
        frame(16'h0000);
        check(rx, 16'h65C3);
    endtask

    task automatic t_alarm();
        logic [2:0] code;
        logic [3:0] e;
        for (int c = 0; c < 8; c++) begin
            code = 3'(c);
            frame({4'h4, 5'h00, code, 4'hC});
            for (int h = 0; h < 2; h++) begin
                @(negedge clk);
                highAlarm = 1'(h);
                lowAlarm = ~1'(h);
                repeat (3) @(negedge clk);
                e = alarm_exp(code, highAlarm, lowAlarm);
                check(16'({pinOe, pinOut[1:0]}), 16'({2'h3, e}));
            end
        end
        // single-pin variant: functions off, pins one to three outputs, alarm on pin_zero
        frame(16'h401E);
        check(16'({pinOe, pinOut[0]}), 16'h001F);
    endtask

    task automatic t_power();
        @(negedge clk) pinIn = 4'hD;
        frame(16'h418F);
        check(16'(pinOe), 16'h0003);
        check(16'(rangeHigh), 16'h0001);
        @(negedge clk) pinIn[3] = 1'b0;
        // two sync flops plus the register, one cycle spare
        repeat (4) @(negedge clk);
        check(16'(powerDown), 16'h0001);
        pinIn[3] = 1'b1;
        repeat (10) @(negedge clk);
        check(16'(powerDown), 16'h0001);
        frame(16'h0000);
        check(16'(powerDown), 16'h0000);
        // mode power-down holds through the next frame start, clears only once written 0
        frame(16'h1020);
        check(16'(powerDown), 16'h0001);
        frame(16'h1000);
        check(16'(powerDown), 16'h0001);
        frame(16'h0000);
        check(16'(powerDown), 16'h0000);
    endtask

    task automatic t_soft();
        frame(16'h1045);
        frame(16'h420F);
        // range select and output data of the mode frame land at this frame's start
        check(16'({pinOe, pinOut, rangeHigh}), 16'h01EB);
        frame(16'h0000);
        check(16'({pinOe, pinOut, rangeHigh}), 16'h0000);
    endtask

    task automatic t_freeze();
        // ce low must hold every system-domain register, the pin synchroniser too
        @(negedge clk) ce = 1'b0;
        pinIn[3] = 1'b0;
        repeat (6) @(negedge clk);
        check(16'(powerDown), 16'h0000);
        ce = 1'b1;
        repeat (4) @(negedge clk);
        check(16'(powerDown), 16'h0001);
        pinIn[3] = 1'b1;
        frame(16'h0000);
        check(16'(powerDown), 16'h0000);
    endtask

    initial begin
        #200us;
        failCount++;
        closeOut();
    end

    initial begin
        clk = 1'b0;
        ce = 1'b1;
        rst_b = 1'b0;
        pinIn = 4'h0;
        convData = 12'h5C3;
        chanAddr = 4'h6;
        highAlarm = 1'b0;
        lowAlarm = 1'b0;
        repeat (15) @(negedge clk);
        check(16'({powerDown, rangeHigh, pinOe, pinOut}), 16'h0000);
        @(negedge clk) rst_b = 1'b1;
        repeat (8) @(negedge clk);
        check(16'({pinOe, pinOut}), 16'h0000);
        t_output();
        t_read();
        t_alarm();
        t_power();
        t_freeze();
        t_soft();
        closeOut();
    end
endmodule
